// [bench/scrl_core_checker.sv]
// assertions on the ports of the stack command core
// assumes one clock domain and the hand-over timing of the core
`timescale 1ns/1ps
module scrl_core_checker #(
  parameter int TO_BASE_CYC = scrl_pkg::SCRL_TO_BASE_CYC,
  parameter int TO_STEP_CYC = scrl_pkg::SCRL_TO_STEP_CYC
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic [3:0]          dev_addr,
  input wire logic                chained,
  input wire scrl_pkg::scrl_cmd_s cmd_in,
  input wire logic                cmd_ready,
  input wire logic                exec_valid,
  input wire logic [5:0]          exec_reg,
  input wire logic [7:0]          exec_wdata,
  input wire logic                exec_done,
  input wire logic [7:0]          reg_rdata,
  input wire logic [7:0]          status_rdata,
  input wire scrl_pkg::scrl_rsp_s down_rsp,
  input wire logic [3:0]          scan_count,
  input wire logic                busy
);
  logic take;
  logic own;
  assign take = cmd_in.valid && cmd_ready && cmd_in.crc_ok;
  assign own  = cmd_in.addr == dev_addr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_rst_idle;
    $fell(reset) |-> cmd_ready && !busy && scan_count == 4'h0;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("core not idle after reset");

  property p_scan_inc;
    take && own && cmd_in.cmd == scrl_pkg::SCRL_CMD_SCAN_VOLT
      |=> scan_count == $past(scan_count) + 4'h1;
  endproperty
  a_scan_inc: assert property (p_scan_inc)
    else $error("scan did not bump the counter");

  property p_reset_nocnt;
    take && cmd_in.cmd == scrl_pkg::SCRL_CMD_RESET |=> $stable(scan_count)[*4];
  endproperty
  a_reset_nocnt: assert property (p_reset_nocnt)
    else $error("reset command moved the counter");

  property p_scan_silent;
    take && cmd_in.cmd < scrl_pkg::SCRL_CMD_MEASURE |=> !down_rsp.valid[*8];
  endproperty
  a_scan_silent: assert property (p_scan_silent)
    else $error("scan produced a reply");

  property p_meas_bc;
    cmd_in.valid && cmd_ready && chained
      && cmd_in.cmd == scrl_pkg::SCRL_CMD_MEASURE
      && cmd_in.addr == scrl_pkg::SCRL_ADDR_ALL |=> $stable(scan_count);
  endproperty
  a_meas_bc: assert property (p_meas_bc)
    else $error("broadcast measure was counted");

  property p_comfail;
    down_rsp.valid && down_rsp.kind == scrl_pkg::SCRL_RSP_COMFAIL
      |-> down_rsp.reg_addr == scrl_pkg::SCRL_STATUS_REG
      && down_rsp.data == $past(status_rdata);
  endproperty
  a_comfail: assert property (p_comfail)
    else $error("failure reply not shaped as a status read");

  property p_data;
    down_rsp.valid && down_rsp.kind == scrl_pkg::SCRL_RSP_DATA
      |-> down_rsp.data == $past(reg_rdata);
  endproperty
  a_data: assert property (p_data)
    else $error("read reply differs from register contents");

  property p_exec_hold;
    exec_valid && !exec_done
      |=> exec_valid && $stable(exec_reg) && $stable(exec_wdata);
  endproperty
  a_exec_hold: assert property (p_exec_hold)
    else $error("execution request dropped before done");
endmodule

bind scrl_core scrl_core_checker #(
  .TO_BASE_CYC(TO_BASE_CYC), .TO_STEP_CYC(TO_STEP_CYC)
) scrl_core_checker_inst (
  .clk(clk), .reset(reset), .dev_addr(dev_addr), .chained(chained),
  .cmd_in(cmd_in), .cmd_ready(cmd_ready), .exec_valid(exec_valid),
  .exec_reg(exec_reg), .exec_wdata(exec_wdata), .exec_done(exec_done),
  .reg_rdata(reg_rdata), .status_rdata(status_rdata),
  .down_rsp(down_rsp), .scan_count(scan_count), .busy(busy)
);

// [bench/scrl_partner.sv]
// far side model: execution engine, register store, device above
// assumes dly of 2 or more so one wait gets exactly one reply
`timescale 1ns/1ps
module scrl_partner (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                is_top,
  input  wire logic                mute,
  input  wire logic [3:0]          dly,
  input  wire logic                exec_valid,
  input  wire scrl_pkg::scrl_cmd_e exec_cmd,
  input  wire logic [5:0]          exec_reg,
  input  wire logic [7:0]          exec_wdata,
  input  wire logic                busy,
  output logic                     exec_done,
  output logic [7:0]               reg_rdata,
  output scrl_pkg::scrl_up_s       up_rsp
);
  logic [7:0] mem [64];
  logic [5:0] raddr;
  logic [3:0] ecnt;
  logic [3:0] ucnt;
  logic       fired;
  assign reg_rdata = mem[raddr];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exec_done <= 1'b0;
      fired     <= 1'b0;
      ecnt      <= 4'h0;
      ucnt      <= 4'h0;
      raddr     <= 6'h00;
      up_rsp    <= '0;
    end else begin
      exec_done   <= 1'b0;
      up_rsp.valid <= 1'b0;
      // an idle reply line keeps moving so stale data is never trusted
      up_rsp.data <= ~up_rsp.data;
      if (!exec_valid) begin
        ecnt  <= 4'h0;
        fired <= 1'b0;
      end else if (!fired && ecnt >= dly) begin
        exec_done <= 1'b1;
        fired     <= 1'b1;
        raddr     <= exec_reg;
        if (exec_cmd == scrl_pkg::SCRL_CMD_WRITE) begin
          mem[exec_reg] <= exec_wdata;
        end
      end else begin
        ecnt <= ecnt + 4'h1;
      end
      // mute stands for a broken link above: no reply ever comes
      if (!busy || exec_valid || is_top || mute || up_rsp.valid) begin
        ucnt <= 4'h0;
      end else if (ucnt >= dly) begin
        up_rsp.valid <= 1'b1;
        up_rsp.kind  <= scrl_pkg::SCRL_RSP_ACK;
        ucnt         <= 4'h0;
      end else begin
        ucnt <= ucnt + 4'h1;
      end
    end
  end
endmodule

// [bench/tb.sv]
// self-checking bench for the stack command core
// assumes the checker binds itself and the partner answers for the far side
`timescale 1ns/1ps
module tb;
  logic                clk;
  logic                reset;
  logic [3:0]          dev_addr;
  logic                chained;
  logic                is_top;
  logic                chain_awake_ok;
  logic                mute;
  logic [3:0]          dly;
  logic [7:0]          status_rdata;
  logic [3:0]          cnt;
  scrl_pkg::scrl_cmd_s cmd_in;
  scrl_pkg::scrl_cmd_e exec_cmd;
  scrl_pkg::scrl_up_s  up_rsp;
  scrl_pkg::scrl_rsp_s down_rsp;
  logic                cmd_ready, exec_valid, exec_done, busy;
  logic [5:0]          exec_reg;
  logic [7:0]          exec_wdata, reg_rdata;
  logic [3:0]          scan_count;
  int                  error_cnt, comparisons, cyc;

  scrl_core #(.TO_BASE_CYC(20), .TO_STEP_CYC(5)) scrl_core_inst (
    .clk(clk), .reset(reset), .dev_addr(dev_addr), .chained(chained),
    .is_top(is_top), .chain_awake_ok(chain_awake_ok), .cmd_in(cmd_in),
    .cmd_ready(cmd_ready), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
    .exec_reg(exec_reg), .exec_wdata(exec_wdata), .exec_done(exec_done),
    .reg_rdata(reg_rdata), .status_rdata(status_rdata), .up_rsp(up_rsp),
    .down_rsp(down_rsp), .scan_count(scan_count), .busy(busy)
  );
  scrl_partner scrl_partner_inst (
    .clk(clk), .reset(reset), .is_top(is_top), .mute(mute), .dly(dly),
    .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_reg(exec_reg),
    .exec_wdata(exec_wdata), .busy(busy), .exec_done(exec_done),
    .reg_rdata(reg_rdata), .up_rsp(up_rsp)
  );

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons = comparisons + 1;
    if (e !== g) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle();
    for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic mode(input logic ch, input logic top, input logic mu);
    @(posedge clk);
    chained <= ch;
    is_top  <= top;
    mute    <= mu;
  endtask
  task automatic op(input scrl_pkg::scrl_cmd_e c, input logic [3:0] a,
                    input logic ok, input logic [7:0] d);
    @(posedge clk);
    cmd_in <= '{1'b1, c, a, 6'h03, d, ok};
    @(posedge clk);
    cmd_in.valid <= 1'b0;
  endtask
  task automatic want(input scrl_pkg::scrl_rsp_e k, input logic [7:0] d);
    for (int i = 0; i < 200 && down_rsp.valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("reply", 8'h01, {7'h0, down_rsp.valid});
    chk("kind", {5'h0, k}, {5'h0, down_rsp.kind});
    chk("addr", {4'h0, dev_addr}, {4'h0, down_rsp.addr});
    if (k == scrl_pkg::SCRL_RSP_DATA || k == scrl_pkg::SCRL_RSP_COMFAIL) begin
      chk("data", d, down_rsp.data);
    end
    settle();
  endtask
  task automatic none();
    logic s;
    s = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      s = s | (down_rsp.valid !== 1'b0);
    end
    chk("silence", 8'h00, {7'h0, s});
    settle();
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    chk("ready", 8'h01, {7'h0, cmd_ready});
    chk("busy", 8'h00, {7'h0, busy});
    chk("count", 8'h00, {4'h0, scan_count});
  endtask
  task automatic t_scans();
    mode(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      op(scrl_pkg::scrl_cmd_e'(i), 4'h2, 1'b1, 8'h00);
      none();
      chk("count", {4'h0, 4'(i + 1)}, {4'h0, scan_count});
    end
    op(scrl_pkg::SCRL_CMD_RESET, 4'h2, 1'b1, 8'h00);
    none();
    chk("count", 8'h06, {4'h0, scan_count});
    mode(1'b1, 1'b0, 1'b0);
    op(scrl_pkg::SCRL_CMD_SCAN_TEMP, scrl_pkg::SCRL_ADDR_ALL, 1'b1, 8'h00);
    none();
    op(scrl_pkg::SCRL_CMD_MEASURE, scrl_pkg::SCRL_ADDR_ALL, 1'b1, 8'h00);
    none();
    chk("count", 8'h07, {4'h0, scan_count});
  endtask
  task automatic t_chain_acks();
    scrl_pkg::scrl_cmd_e l[5];
    l = '{scrl_pkg::SCRL_CMD_CSUM_CALC, scrl_pkg::SCRL_CMD_CSUM_CHECK,
          scrl_pkg::SCRL_CMD_ACK, scrl_pkg::SCRL_CMD_NAK,
          scrl_pkg::SCRL_CMD_BAL_EN};
    dly <= 4'h9;
    op(scrl_pkg::SCRL_CMD_WRITE, 4'h2, 1'b1, 8'h5A);
    want(scrl_pkg::SCRL_RSP_ACK, 8'h00);
    dly <= 4'h2;
    for (int i = 0; i < 5; i++) begin
      op(l[i], 4'h2, 1'b1, 8'h00);
      want(scrl_pkg::SCRL_RSP_ACK, 8'h00);
    end
    op(scrl_pkg::SCRL_CMD_WRITE, 4'h2, 1'b0, 8'h11);
    want(scrl_pkg::SCRL_RSP_NAK, 8'h00);
  endtask
  task automatic t_alone_read();
    mode(1'b0, 1'b0, 1'b0);
    op(scrl_pkg::SCRL_CMD_READ, 4'h2, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_DATA, 8'h5A);
    op(scrl_pkg::SCRL_CMD_WRITE, 4'h2, 1'b1, 8'hA5);
    none();
    op(scrl_pkg::SCRL_CMD_READ, 4'h2, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_DATA, 8'hA5);
  endtask
  task automatic t_top();
    mode(1'b1, 1'b1, 1'b0);
    op(scrl_pkg::SCRL_CMD_SLEEP, scrl_pkg::SCRL_ADDR_ALL, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_ACK, 8'h00);
    op(scrl_pkg::SCRL_CMD_SLEEP, 4'h2, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_NAK, 8'h00);
    op(scrl_pkg::SCRL_CMD_IDENTIFY, scrl_pkg::SCRL_ADDR_IDENT, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_ACK, 8'h00);
    op(scrl_pkg::SCRL_CMD_WAKEUP, scrl_pkg::SCRL_ADDR_ALL, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_ACK, 8'h00);
    chain_awake_ok <= 1'b0;
    op(scrl_pkg::SCRL_CMD_WAKEUP, scrl_pkg::SCRL_ADDR_ALL, 1'b1, 8'h00);
    none();
    chain_awake_ok <= 1'b1;
  endtask
  task automatic t_timeout();
    mode(1'b1, 1'b0, 1'b1);
    op(scrl_pkg::SCRL_CMD_WRITE, 4'h2, 1'b1, 8'h3C);
    want(scrl_pkg::SCRL_RSP_COMFAIL, 8'hC3);
    mode(1'b1, 1'b0, 1'b0);
    op(scrl_pkg::SCRL_CMD_WAKEUP, 4'h2, 1'b1, 8'h00);
    want(scrl_pkg::SCRL_RSP_ECHO, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    dev_addr = 4'h2;
    chained = 1'b0;
    is_top = 1'b0;
    chain_awake_ok = 1'b1;
    mute = 1'b0;
    dly = 4'h2;
    status_rdata = 8'hC3;
    cmd_in = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_scans();
    t_chain_acks();
    t_alone_read();
    t_top();
    t_timeout();
    print_verdict();
  end
endmodule

// [common/scrl_pkg.sv]
// package for the stack command and response logic
// assumes one synchronous clock domain; commands arrive already framed
package scrl_pkg;

  // ****************************************
  // command codes (block-internal encoding)
  // ****************************************
  typedef enum logic [4:0] {
    SCRL_CMD_SCAN_VOLT  = 5'h00,
    SCRL_CMD_SCAN_TEMP  = 5'h01,
    SCRL_CMD_SCAN_MIXED = 5'h02,
    SCRL_CMD_SCAN_WIRES = 5'h03,
    SCRL_CMD_SCAN_ALL   = 5'h04,
    SCRL_CMD_MEASURE    = 5'h05,
    SCRL_CMD_RESET      = 5'h06,
    SCRL_CMD_WAKEUP     = 5'h07,
    SCRL_CMD_SLEEP      = 5'h08,
    SCRL_CMD_IDENTIFY   = 5'h09,
    SCRL_CMD_NAK        = 5'h0A,
    SCRL_CMD_ACK        = 5'h0B,
    SCRL_CMD_READ       = 5'h0C,
    SCRL_CMD_WRITE      = 5'h0D,
    SCRL_CMD_SCAN_CONT  = 5'h0E,
    SCRL_CMD_SCAN_INH   = 5'h0F,
    SCRL_CMD_BAL_EN     = 5'h10,
    SCRL_CMD_BAL_INH    = 5'h11,
    SCRL_CMD_CSUM_CALC  = 5'h12,
    SCRL_CMD_CSUM_CHECK = 5'h13
  } scrl_cmd_e;

  // ****************************************
  // reply kinds sent downward / to host
  // ****************************************
  typedef enum logic [2:0] {
    SCRL_RSP_ACK      = 3'h1,
    SCRL_RSP_NAK      = 3'h2,
    SCRL_RSP_DATA     = 3'h3,
    SCRL_RSP_ECHO     = 3'h4,
    SCRL_RSP_COMFAIL  = 3'h5
  } scrl_rsp_e;

  localparam int          SCRL_ADDR_W       = 4;
  localparam int          SCRL_REG_AW       = 6;
  localparam int          SCRL_DATA_W       = 8;
  localparam logic [3:0]  SCRL_ADDR_ALL     = 4'hF;
  localparam logic [3:0]  SCRL_ADDR_MIN     = 4'h1;
  localparam logic [3:0]  SCRL_ADDR_MAX     = 4'hE;
  localparam logic [3:0]  SCRL_ADDR_IDENT   = 4'h0;
  localparam logic [5:0]  SCRL_STATUS_REG   = 6'h00;
  localparam int          SCRL_SCNT_W       = 4;
  localparam logic [3:0]  SCRL_SCNT_RST     = 4'h0;

  // reply timeout: base time plus a step per stack position
  localparam int          SCRL_CLK_MHZ      = 125;
  localparam int          SCRL_TO_BASE_US   = 20;
  localparam int          SCRL_TO_STEP_US   = 10;
  localparam int          SCRL_TO_BASE_CYC  = SCRL_TO_BASE_US * SCRL_CLK_MHZ;
  localparam int          SCRL_TO_STEP_CYC  = SCRL_TO_STEP_US * SCRL_CLK_MHZ;
  localparam int          SCRL_TO_W         = 16;

  typedef struct packed {
    logic                   valid;
    scrl_cmd_e              cmd;
    logic [3:0]             addr;
    logic [5:0]             reg_addr;
    logic [7:0]             wdata;
    logic                   crc_ok;
  } scrl_cmd_s;

  typedef struct packed {
    logic                   valid;
    scrl_rsp_e              kind;
    logic [3:0]             addr;
    logic [5:0]             reg_addr;
    logic [7:0]             data;
  } scrl_rsp_s;

  typedef struct packed {
    logic                   valid;
    scrl_rsp_e              kind;
    logic [7:0]             data;
  } scrl_up_s;

  typedef struct packed {
    logic                   go;
    logic                   reply;
    logic                   to_top;
    logic                   scan_inc;
    logic                   execute;
    scrl_rsp_e              kind;
  } scrl_dec_s;

endpackage

// [rtl/scrl_core.sv]
// stack command and response logic: command handling for one device
// assumes framed, checked commands arrive as one-cycle pulses and that
// register storage and scan engines live outside this block
//
// Notes on behaviour
// [RL1] action command executes, then acknowledges
// [RL2] write stores data, then acknowledges
// [RL3] read returns current register contents
// [RL4] scans give no reply, bump counter
// [RL5] standalone host expects replies only for reads
// [RL6] chain: top or target answers most commands
// [RL7] wait for reply from above first
// [RL8] broadcast wakeup: silent if chain has gap
// [RL9] no reply above in time: comm failure
// [RL10] host tracks outstanding commands and failures
// [RL11] ack means received; nak means decode failed
// [RL12] five scans: broadcast ok, count, silent
// [RL13] measure: no broadcast, silent, counts
// [RL14] reset: no broadcast, silent, no count
// [RL15] sleep broadcast only; top ack, target nak (a target below the top relays the reply kind from above)
// [RL16] identify chain only; top ack, target nak
// [RL17] read: data standalone; chain target data
// [RL18] ack/nak commands chain only, acknowledged
// [RL19] checksum commands acknowledged, no broadcast
// [RL20] scan/balance control: broadcast ok, no count
// [RL21] those acknowledged by target, broadcast by top
// [RL22] addresses 1 to 14, 15 broadcast
// [RL23] addressed wakeup echoes if all awake
// [RL24] reset leaves handler idle, timer clear
`timescale 1ns/1ps
module scrl_core #(
  parameter int TO_BASE_CYC = scrl_pkg::SCRL_TO_BASE_CYC,
  parameter int TO_STEP_CYC = scrl_pkg::SCRL_TO_STEP_CYC
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [3:0]          dev_addr,
  input  wire logic                chained,
  input  wire logic                is_top,
  input  wire logic                chain_awake_ok,
  input  wire scrl_pkg::scrl_cmd_s cmd_in,
  output logic                     cmd_ready,
  output logic                     exec_valid,
  output scrl_pkg::scrl_cmd_e      exec_cmd,
  output logic [5:0]               exec_reg,
  output logic [7:0]               exec_wdata,
  input  wire logic                exec_done,
  input  wire logic [7:0]          reg_rdata,
  input  wire logic [7:0]          status_rdata,
  input  wire scrl_pkg::scrl_up_s  up_rsp,
  output scrl_pkg::scrl_rsp_s      down_rsp,
  output logic [3:0]               scan_count,
  output logic                     busy
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    SCRL_IDLE = 4'h1,
    SCRL_EXEC = 4'h2,
    SCRL_WAIT = 4'h4,
    SCRL_SEND = 4'h8
  } scrl_state_e;

  typedef struct packed {
    scrl_state_e          state;
    scrl_pkg::scrl_cmd_s  cmd;
    scrl_pkg::scrl_dec_s  dec;
    scrl_pkg::scrl_rsp_s  rsp;
    logic [3:0]           scnt;
  } scrl_core_s;

  scrl_core_s st_r;
  scrl_core_s st_nxt;

  scrl_pkg::scrl_dec_s dec;
  logic                to_start;
  logic                to_stop;
  logic                to_expired;
  logic                need_up;

  // ****************************************
  // decode and reply timer
  // ****************************************
  scrl_decode u_decode (
    .cmd            (cmd_in),
    .dev_addr       (dev_addr),
    .chained        (chained),
    .is_top         (is_top),
    .chain_awake_ok (chain_awake_ok),
    .dec            (dec)
  );

  scrl_timeout #(
    .BASE_CYC (TO_BASE_CYC),
    .STEP_CYC (TO_STEP_CYC)
  ) u_timeout (
    .clk      (clk),
    .reset    (reset),
    .start    (to_start),
    .stop     (to_stop),
    .position (dev_addr),
    .expired  (to_expired)
  );

  // a device below the top must hear from above before answering
  assign need_up = chained && !is_top;

  // ****************************************
  // command sequencing
  // ****************************************
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rsp.valid = 1'b0;
    to_start     = 1'b0;
    to_stop      = 1'b0;
    case (st_r.state)
      SCRL_IDLE: begin
        if (dec.go) begin
          st_nxt.cmd = cmd_in;
          st_nxt.dec = dec;
          if (dec.scan_inc) begin
            st_nxt.scnt = st_r.scnt + 4'h1;                 // [RL4] [RL12]
          end
          if (dec.execute) begin
            st_nxt.state = SCRL_EXEC;
          end else if (dec.reply && need_up) begin
            st_nxt.state = SCRL_WAIT;
            to_start     = 1'b1;
          end else if (dec.reply) begin
            st_nxt.state = SCRL_SEND;
          end
        end
      end
      SCRL_EXEC: begin
        if (exec_done) begin                                // [RL1] [RL2]
          if (!st_r.dec.reply) begin
            st_nxt.state = SCRL_IDLE;                       // [RL14]
          end else if (need_up) begin
            st_nxt.state = SCRL_WAIT;
            to_start     = 1'b1;
          end else begin
            st_nxt.state = SCRL_SEND;
          end
        end
      end
      SCRL_WAIT: begin
        if (up_rsp.valid) begin                             // [RL7]
          to_stop = 1'b1;
          st_nxt.state = SCRL_SEND;
          // a reply from above for a top-answered command is relayed
          if (st_r.dec.to_top) begin
            st_nxt.dec.kind = up_rsp.kind;
          end
        end else if (to_expired) begin
          st_nxt.state        = SCRL_IDLE;
          st_nxt.rsp.valid    = 1'b1;                       // [RL9]
          st_nxt.rsp.kind     = scrl_pkg::SCRL_RSP_COMFAIL;
          st_nxt.rsp.addr     = dev_addr;
          st_nxt.rsp.reg_addr = scrl_pkg::SCRL_STATUS_REG;
          st_nxt.rsp.data     = status_rdata;
        end
      end
      SCRL_SEND: begin
        st_nxt.state        = SCRL_IDLE;
        st_nxt.rsp.valid    = 1'b1;                         // [RL6]
        st_nxt.rsp.kind     = st_r.dec.kind;                // [RL11]
        st_nxt.rsp.addr     = dev_addr;
        st_nxt.rsp.reg_addr = st_r.cmd.reg_addr;
        st_nxt.rsp.data     = (st_r.dec.kind == scrl_pkg::SCRL_RSP_DATA)
                              ? reg_rdata : 8'h00;          // [RL3] [RL17]
      end
      default: begin
        st_nxt.state = SCRL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r       <= '0;                                     // [RL24]
      st_r.state <= SCRL_IDLE;
      st_r.scnt  <= scrl_pkg::SCRL_SCNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cmd_ready  = (st_r.state == SCRL_IDLE);
  assign exec_valid = (st_r.state == SCRL_EXEC);
  assign exec_cmd   = st_r.cmd.cmd;
  assign exec_reg   = st_r.cmd.reg_addr;
  assign exec_wdata = st_r.cmd.wdata;
  assign down_rsp   = st_r.rsp;
  assign scan_count = st_r.scnt;
  assign busy       = (st_r.state != SCRL_IDLE);

endmodule

// [rtl/scrl_decode.sv]
// command attribute decoder: who answers, what with, scan counter effect
// purely combinational; role and address come from the main module
`timescale 1ns/1ps
module scrl_decode (
  input  wire scrl_pkg::scrl_cmd_s cmd,
  input  wire logic [3:0]          dev_addr,
  input  wire logic                chained,
  input  wire logic                is_top,
  input  wire logic                chain_awake_ok,
  output scrl_pkg::scrl_dec_s      dec
);

  logic bcast;
  logic mine;
  logic ok_addr;

  always_comb begin
    bcast   = (cmd.addr == scrl_pkg::SCRL_ADDR_ALL) && chained; // [RL22]
    mine    = (cmd.addr == dev_addr) || !chained;
    ok_addr = mine;
    dec     = '0;
    dec.kind = scrl_pkg::SCRL_RSP_ACK;
    case (cmd.cmd)
      scrl_pkg::SCRL_CMD_SCAN_VOLT, scrl_pkg::SCRL_CMD_SCAN_TEMP,
      scrl_pkg::SCRL_CMD_SCAN_MIXED, scrl_pkg::SCRL_CMD_SCAN_WIRES,
      scrl_pkg::SCRL_CMD_SCAN_ALL: begin
        dec.execute  = mine || bcast;                       // [RL12]
        dec.scan_inc = dec.execute;                         // [RL4]
      end
      scrl_pkg::SCRL_CMD_MEASURE: begin
        dec.execute  = mine;                                // [RL13]
        dec.scan_inc = mine;
      end
      scrl_pkg::SCRL_CMD_RESET: begin
        dec.execute  = mine;                                // [RL14]
      end
      scrl_pkg::SCRL_CMD_WAKEUP: begin
        dec.execute = mine || bcast;
        if (bcast) begin
          dec.reply  = is_top && chain_awake_ok;            // [RL8]
          dec.to_top = 1'b1;
        end else if (mine && chained) begin
          dec.reply = chain_awake_ok;                       // [RL23]
          dec.kind  = scrl_pkg::SCRL_RSP_ECHO;
        end
      end
      scrl_pkg::SCRL_CMD_SLEEP: begin
        dec.execute = bcast;                                // [RL15]
        dec.to_top  = 1'b1;
        dec.reply   = chained && (bcast ? is_top : mine);
        dec.kind    = bcast ? scrl_pkg::SCRL_RSP_ACK
                            : scrl_pkg::SCRL_RSP_NAK;
      end
      scrl_pkg::SCRL_CMD_IDENTIFY: begin
        dec.execute = chained &&
                      (cmd.addr == scrl_pkg::SCRL_ADDR_IDENT); // [RL16]
        dec.reply   = chained && (is_top || mine);
        dec.to_top  = dec.execute;
        dec.kind    = dec.execute ? scrl_pkg::SCRL_RSP_ACK
                                  : scrl_pkg::SCRL_RSP_NAK;
      end
      scrl_pkg::SCRL_CMD_NAK, scrl_pkg::SCRL_CMD_ACK: begin
        dec.execute = chained && mine;                      // [RL18]
        dec.reply   = dec.execute;
      end
      scrl_pkg::SCRL_CMD_READ: begin
        dec.execute = mine;                                 // [RL17]
        dec.reply   = mine;
        dec.kind    = scrl_pkg::SCRL_RSP_DATA;              // [RL3]
      end
      scrl_pkg::SCRL_CMD_WRITE,
      scrl_pkg::SCRL_CMD_CSUM_CALC, scrl_pkg::SCRL_CMD_CSUM_CHECK: begin
        dec.execute = mine;                                 // [RL2] [RL19]
        dec.reply   = mine && chained;
      end
      scrl_pkg::SCRL_CMD_SCAN_CONT, scrl_pkg::SCRL_CMD_SCAN_INH,
      scrl_pkg::SCRL_CMD_BAL_EN, scrl_pkg::SCRL_CMD_BAL_INH: begin
        dec.execute = mine || bcast;                        // [RL20]
        dec.reply   = chained && (bcast ? is_top : mine);   // [RL21]
        dec.to_top  = bcast;
      end
      default: begin
        dec.execute = 1'b0;
      end
    endcase
    // a failed decode still earns a not-acknowledge from the target
    if (!cmd.crc_ok) begin
      dec.execute  = 1'b0;
      dec.scan_inc = 1'b0;
      dec.reply    = chained && mine;                       // [RL11]
      dec.kind     = scrl_pkg::SCRL_RSP_NAK;
      dec.to_top   = 1'b0;
    end
    dec.go = cmd.valid && (dec.execute || dec.reply);
    if (!ok_addr && !bcast && cmd.cmd != scrl_pkg::SCRL_CMD_IDENTIFY) begin
      dec.reply = dec.reply && dec.to_top;
    end
  end

endmodule

// [rtl/scrl_timeout.sv]
// reply wait timer; limit grows as the position number in the stack falls
// restarted by start, cleared by stop; expired is a one-cycle pulse
`timescale 1ns/1ps
module scrl_timeout #(
  parameter int BASE_CYC = scrl_pkg::SCRL_TO_BASE_CYC,
  parameter int STEP_CYC = scrl_pkg::SCRL_TO_STEP_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              start,
  input  wire logic                              stop,
  input  wire logic [3:0]                        position,
  output logic                                   expired
);

  typedef struct packed {
    logic                           run;
    logic [scrl_pkg::SCRL_TO_W-1:0] cnt;
    logic                           exp;
  } scrl_to_s;

  scrl_to_s st_r;
  scrl_to_s st_nxt;
  logic [scrl_pkg::SCRL_TO_W-1:0] limit;

  // devices further down wait longer so the one nearest the break reports
  assign limit = scrl_pkg::SCRL_TO_W'(BASE_CYC +
                 STEP_CYC * (15 - int'(position)));

  always_comb begin
    st_nxt     = st_r;
    st_nxt.exp = 1'b0;
    if (start) begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = '0;
    end else if (stop) begin
      st_nxt.run = 1'b0;
      st_nxt.cnt = '0;
    end else if (st_r.run) begin
      if (st_r.cnt >= limit - 16'h0001) begin
        st_nxt.run = 1'b0;
        st_nxt.cnt = '0;
        st_nxt.exp = 1'b1;                                  // [RL9]
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;                                           // [RL24]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.exp;

endmodule
